// ==== src/dcr_pkg.sv ====
// ****************************************************************
// Shared constants of the device control register block
// ****************************************************************
package dcr_pkg;
    // Register bus widths
    localparam int DCR_ADDR_W = 8;
    localparam int DCR_DATA_W = 8;
    // Register byte addresses
    localparam logic [7:0] DCR_ADDR_DIV_SYNC = 8'h3d;
    localparam logic [7:0] DCR_ADDR_PLL_PLL_LOCK_RESTART_CMD = 8'h3e;
    localparam logic [7:0] DCR_ADDR_BIAS_CAL = 8'h3f;
    localparam logic [7:0] DCR_ADDR_BANK_EN = 8'h40;
    // Command bit position in each command register
    localparam int DCR_CMD_BIT = 7;
    // Bank enable field positions in the enable register
    localparam int DCR_EN_A_BIT = 3;
    localparam int DCR_EN_B_BIT = 2;
    localparam int DCR_EN_C_BIT = 1;
    localparam int DCR_EN_D_BIT = 0;
    localparam int DCR_EN_W = 4;
    // Reset values
    localparam logic [3:0] DCR_EN_RESET = 4'hf;
    localparam logic [7:0] DCR_RDATA_RESET = 8'h00;
    localparam logic [7:0] DCR_RDATA_ZERO = 8'h00;
    localparam logic [3:0] DCR_EN_PAD_ZERO = 4'h0;
    // Output counts per bank
    localparam int DCR_A_W = 4;
    localparam int DCR_B_W = 4;
    localparam int DCR_C_W = 2;
    // Disabled levels of the outputs
    localparam logic [3:0] DCR_LOW4 = 4'h0;
    localparam logic [3:0] DCR_HIGH4 = 4'hf;
    localparam logic [1:0] DCR_LOW2 = 2'h0;
    localparam logic [1:0] DCR_HIGH2 = 2'h3;
endpackage

// ==== src/dcr_gate_if.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Carrier between the register core and the output gate
// ****************************************************************
interface dcr_gate_if;
    logic [3:0] bank_en; // Enables A, B, C, D at bits 3..0
    logic bank_d_powerdown; // Whole bank D powered down
    logic bank_d_single_ended_powerdown; // Single-ended D powered down
    logic [3:0] raw_a; // Ungated bank A clocks
    logic [3:0] raw_b; // Ungated bank B clocks
    logic [1:0] raw_c; // Ungated bank C clocks
    logic raw_d0; // Ungated bank D differential clock
    logic raw_d1; // Ungated bank D single-ended clock
    logic [3:0] a_true; // Gated bank A true legs
    logic [3:0] a_comp; // Gated bank A complement legs
    logic [3:0] b_true; // Gated bank B true legs
    logic [3:0] b_comp; // Gated bank B complement legs
    logic [1:0] c_true; // Gated bank C true legs
    logic [1:0] c_comp; // Gated bank C complement legs
    logic d0_true; // Gated bank D true leg
    logic d0_comp; // Gated bank D complement leg
    logic d1_out; // Single-ended D level
    logic d1_oe_n; // Single-ended D enable, low drives
    // Core side
    modport core (output bank_en, bank_d_powerdown, bank_d_single_ended_powerdown,
        raw_a, raw_b, raw_c, raw_d0, raw_d1,
        input a_true, a_comp, b_true, b_comp, c_true, c_comp, d0_true, d0_comp,
        d1_out, d1_oe_n);
    // Gate side
    modport gate (input bank_en, bank_d_powerdown, bank_d_single_ended_powerdown,
        raw_a, raw_b, raw_c, raw_d0, raw_d1,
        output a_true, a_comp, b_true, b_comp, c_true, c_comp, d0_true, d0_comp,
        d1_out, d1_oe_n);
endinterface

// ==== src/dcr_output_gate.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Bank output gate: forces disabled banks to logic low
// ****************************************************************
module dcr_output_gate
    import dcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Link to the register core
    dcr_gate_if.gate gif
);
    logic [3:0] next_a_true; // Next bank A true legs
    logic [3:0] next_a_comp; // Next bank A complement legs
    logic [3:0] next_b_true; // Next bank B true legs
    logic [3:0] next_b_comp; // Next bank B complement legs
    logic [1:0] next_c_true; // Next bank C true legs
    logic [1:0] next_c_comp; // Next bank C complement legs
    logic next_d0_true; // Next bank D true leg
    logic next_d0_comp; // Next bank D complement leg
    logic next_d1_out; // Next single-ended level
    logic next_d1_oe_n; // Next single-ended enable
    logic d_off; // Bank D single-ended output released

    // Next output levels from enables and power-down
    always_comb begin
        next_a_true = gif.bank_en[DCR_EN_A_BIT] ? gif.raw_a : DCR_LOW4;
        next_a_comp = gif.bank_en[DCR_EN_A_BIT] ? ~gif.raw_a : DCR_HIGH4;
        next_b_true = gif.bank_en[DCR_EN_B_BIT] ? gif.raw_b : DCR_LOW4;
        next_b_comp = gif.bank_en[DCR_EN_B_BIT] ? ~gif.raw_b : DCR_HIGH4;
        next_c_true = gif.bank_en[DCR_EN_C_BIT] ? gif.raw_c : DCR_LOW2;
        next_c_comp = gif.bank_en[DCR_EN_C_BIT] ? ~gif.raw_c : DCR_HIGH2;
        d_off = gif.bank_d_powerdown | gif.bank_d_single_ended_powerdown;
        if (gif.bank_en[DCR_EN_D_BIT] && !gif.bank_d_powerdown) begin
            // Bank D running
            next_d0_true = gif.raw_d0;
            next_d0_comp = ~gif.raw_d0;
            next_d1_out = gif.raw_d1;
        end else begin
            // Disabled or powered down: held low
            next_d0_true = 1'b0;
            next_d0_comp = 1'b1;
            next_d1_out = 1'b0;
        end
        // Power-down releases the single-ended pin
        next_d1_oe_n = d_off;
    end

    // Output registers
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gif.a_true <= DCR_LOW4;
            gif.a_comp <= DCR_HIGH4;
            gif.b_true <= DCR_LOW4;
            gif.b_comp <= DCR_HIGH4;
            gif.c_true <= DCR_LOW2;
            gif.c_comp <= DCR_HIGH2;
            gif.d0_true <= 1'b0;
            gif.d0_comp <= 1'b1;
            gif.d1_out <= 1'b0;
            gif.d1_oe_n <= 1'b1;
        end else begin
            gif.a_true <= next_a_true;
            gif.a_comp <= next_a_comp;
            gif.b_true <= next_b_true;
            gif.b_comp <= next_b_comp;
            gif.c_true <= next_c_true;
            gif.c_comp <= next_c_comp;
            gif.d0_true <= next_d0_true;
            gif.d0_comp <= next_d0_comp;
            gif.d1_out <= next_d1_out;
            gif.d1_oe_n <= next_d1_oe_n;
        end
    end

    // Disabled banks A, C, D held low; powered-down single-ended D released; enabled B passes its clock
    bank_a_low_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !gif.bank_en[DCR_EN_A_BIT] |=> (gif.a_true == 4'h0) && (gif.a_comp == 4'hf))
        else $error("bank A not held low while disabled");
    bank_c_low_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !gif.bank_en[DCR_EN_C_BIT] |=> (gif.c_true == 2'h0) && (gif.c_comp == 2'h3))
        else $error("bank C not held low while disabled");
    bank_d_low_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !gif.bank_en[DCR_EN_D_BIT] && !d_off |=> !gif.d1_out && !gif.d1_oe_n && !gif.d0_true)
        else $error("bank D not driven low while disabled");
    single_ended_hiz_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (gif.bank_d_powerdown || gif.bank_d_single_ended_powerdown) |=> gif.d1_oe_n)
        else $error("single-ended D driven while powered down");
    bank_b_run_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        gif.bank_en[DCR_EN_B_BIT] |=> (gif.b_true == $past(gif.raw_b)) && (gif.b_comp == ~gif.b_true))
        else $error("bank B not passing its clock while enabled");
endmodule

// ==== src/dcr_device_control.sv ====
`timescale 1ns/10ps
module dcr_device_control
    import dcr_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Register access port
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [DCR_ADDR_W-1:0] reg_addr_in,
    input wire logic [DCR_DATA_W-1:0] reg_wdata_in,
    output logic [DCR_DATA_W-1:0] reg_rdata_out,
    // Command triggers
    output logic divider_sync_cmd_out,
    output logic pll_lock_restart_cmd_out,
    output logic bias_calibrate_cmd_out,
    // Bank D power-down controls from the bank D block
    input wire logic bank_d_powerdown_in,
    input wire logic bank_d_single_ended_powerdown_in,
    // Ungated bank clocks
    input wire logic [DCR_A_W-1:0] bank_a_clk_in,
    input wire logic [DCR_B_W-1:0] bank_b_clk_in,
    input wire logic [DCR_C_W-1:0] bank_c_clk_in,
    input wire logic bank_d_diff_clk_in,
    input wire logic bank_d_single_ended_clk_in,
    // Bank A outputs
    output logic [DCR_A_W-1:0] bank_a_diff_outputs_true_out,
    output logic [DCR_A_W-1:0] bank_a_diff_outputs_comp_out,
    // Bank B outputs
    output logic [DCR_B_W-1:0] bank_b_diff_outputs_true_out,
    output logic [DCR_B_W-1:0] bank_b_diff_outputs_comp_out,
    // Bank C outputs
    output logic [DCR_C_W-1:0] bank_c_diff_outputs_true_out,
    output logic [DCR_C_W-1:0] bank_c_diff_outputs_comp_out,
    // Bank D outputs
    output logic bank_d_diff_output_true_out,
    output logic bank_d_diff_output_comp_out,
    output logic bank_d_single_ended_out,
    output logic bank_d_single_ended_oe_n_out
);
    // ****************************************************************
    // Helpers
    // ****************************************************************

    // True when a write with the command bit set hits the given address
    function automatic logic cmd_hit(input logic wr, input logic [7:0] addr,
        input logic [7:0] wdata, input logic [7:0] target);
        cmd_hit = wr && (addr == target) && wdata[DCR_CMD_BIT];
    endfunction

    // ****************************************************************
    // Command triggers
    // ****************************************************************

    logic next_sync; // Next divider sync pulse
    logic next_pll_lock_restart_cmd; // Next PLL pll_lock_restart_cmd pulse
    logic next_cal; // Next bias calibration pulse

    // Pulse lasts only the cycle after the setting write
    always_comb begin
        next_sync = cmd_hit(reg_write_in, reg_addr_in, reg_wdata_in,
            DCR_ADDR_DIV_SYNC);
        next_pll_lock_restart_cmd = cmd_hit(reg_write_in, reg_addr_in, reg_wdata_in,
            DCR_ADDR_PLL_PLL_LOCK_RESTART_CMD);
        next_cal = cmd_hit(reg_write_in, reg_addr_in, reg_wdata_in,
            DCR_ADDR_BIAS_CAL);
    end

    // Trigger registers; nothing is stored, so the bits self-clear
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            divider_sync_cmd_out <= 1'b0;
            pll_lock_restart_cmd_out <= 1'b0;
            bias_calibrate_cmd_out <= 1'b0;
        end else begin
            divider_sync_cmd_out <= next_sync;
            pll_lock_restart_cmd_out <= next_pll_lock_restart_cmd;
            bias_calibrate_cmd_out <= next_cal;
        end
    end

    // ****************************************************************
    // Bank enable register
    // ****************************************************************

    logic [DCR_EN_W-1:0] bank_en; // Enables A, B, C, D
    logic [DCR_EN_W-1:0] next_bank_en; // Next enables

    // Only the low four bits are kept; reserved bits are dropped
    always_comb begin
        next_bank_en = bank_en;
        if (reg_write_in && (reg_addr_in == DCR_ADDR_BANK_EN)) begin
            next_bank_en = reg_wdata_in[DCR_EN_W-1:0];
        end
    end

    // Enables come out of reset all on
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bank_en <= DCR_EN_RESET;
        end else begin
            bank_en <= next_bank_en;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************

    logic [DCR_DATA_W-1:0] next_rdata; // Next read data

    // Read data updates on a read, holds otherwise
    always_comb begin
        next_rdata = reg_rdata_out;
        if (reg_read_in) begin
            case (reg_addr_in)
                // Command registers always read zero
                DCR_ADDR_DIV_SYNC,
                DCR_ADDR_PLL_PLL_LOCK_RESTART_CMD,
                DCR_ADDR_BIAS_CAL: begin
                    next_rdata = DCR_RDATA_ZERO;
                end
                // Enables in the low bits, reserved bits zero
                DCR_ADDR_BANK_EN: begin
                    next_rdata = {DCR_EN_PAD_ZERO, bank_en};
                end
                // Unmapped addresses read zero
                default: begin
                    next_rdata = DCR_RDATA_ZERO;
                end
            endcase
        end
    end

    // Read data register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= DCR_RDATA_RESET;
        end else begin
            reg_rdata_out <= next_rdata;
        end
    end

    // ****************************************************************
    // Output gate
    // ****************************************************************

    dcr_gate_if gif ();

    // Drive the gate inputs
    assign gif.bank_en = bank_en;
    assign gif.bank_d_powerdown = bank_d_powerdown_in;
    assign gif.bank_d_single_ended_powerdown = bank_d_single_ended_powerdown_in;
    assign gif.raw_a = bank_a_clk_in;
    assign gif.raw_b = bank_b_clk_in;
    assign gif.raw_c = bank_c_clk_in;
    assign gif.raw_d0 = bank_d_diff_clk_in;
    assign gif.raw_d1 = bank_d_single_ended_clk_in;

    dcr_output_gate u_gate (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .gif(gif.gate)
    );

    // Gated outputs to the pins
    assign bank_a_diff_outputs_true_out = gif.a_true;
    assign bank_a_diff_outputs_comp_out = gif.a_comp;
    assign bank_b_diff_outputs_true_out = gif.b_true;
    assign bank_b_diff_outputs_comp_out = gif.b_comp;
    assign bank_c_diff_outputs_true_out = gif.c_true;
    assign bank_c_diff_outputs_comp_out = gif.c_comp;
    assign bank_d_diff_output_true_out = gif.d0_true;
    assign bank_d_diff_output_comp_out = gif.d0_comp;
    assign bank_d_single_ended_out = gif.d1_out;
    assign bank_d_single_ended_oe_n_out = gif.d1_oe_n;

    // ****************************************************************
    // Checks
    // ****************************************************************

    // A setting write triggers divider sync on the next cycle
    sync_trigger_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        reg_write_in && (reg_addr_in == 8'h3d) && reg_wdata_in[7] |=> divider_sync_cmd_out)
        else $error("divider sync not triggered");
    // Pll_lock_restart_cmd pulse only follows a setting write
    pll_lock_restart_cmd_cause_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pll_lock_restart_cmd_out |-> $past(reg_write_in) && ($past(reg_addr_in) == 8'h3e)
            && $past(reg_wdata_in[7]))
        else $error("pll_lock_restart_cmd pulse without a setting write");
    // Calibration pulse is exactly one cycle for a single write
    cal_single_pulse_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $rose(bias_calibrate_cmd_out) && !(reg_write_in && (reg_addr_in == 8'h3f))
            |=> !bias_calibrate_cmd_out)
        else $error("calibration pulse longer than one cycle");
    // Zero written to the divider sync command bit triggers nothing
    cmd_zero_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        reg_write_in && (reg_addr_in == 8'h3d) && !reg_wdata_in[7] |=> !divider_sync_cmd_out)
        else $error("zero write triggered divider sync");
    // Command registers read back as zero
    cmd_read_zero_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        reg_read_in && (reg_addr_in >= 8'h3d) && (reg_addr_in <= 8'h3f) |=> reg_rdata_out == 8'h00)
        else $error("command register read nonzero");
    // Enable write is read back on a following read
    enable_readback_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        reg_write_in && (reg_addr_in == 8'h40) ##1 reg_read_in && (reg_addr_in == 8'h40)
            && !reg_write_in |=> reg_rdata_out == {4'h0, $past(reg_wdata_in[3:0], 2)})
        else $error("bank enables not read back as written");
endmodule

// ==== verification/dcr_device_control_tb_top.sv ====
`timescale 1ns/10ps
module dcr_device_control_tb_top
    import dcr_pkg::*;
;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic clk_in = 1'b0; // 250 MHz bench clock
    logic reset_n_in = 1'b0; // Asynchronous reset, held low at start
    logic wr_en = 1'b0; // Write strobe
    logic rd_en = 1'b0; // Read strobe
    logic [7:0] addr = 8'h00; // Register address
    logic [7:0] wdata = 8'h00; // Write data
    logic pd = 1'b0; // Bank D power-down
    logic sepd = 1'b0; // Single-ended D power-down
    logic [3:0] a_clk = 4'ha; // Bank A clocks, mixed levels
    logic [3:0] b_clk = 4'h5; // Bank B clocks
    logic [1:0] c_clk = 2'h1; // Bank C clocks
    logic d_clk = 1'b1; // Bank D differential clock
    logic se_clk = 1'b1; // Bank D single-ended clock
    logic [7:0] rdata; // Read data
    logic sync_p, pll_lock_restart_cmd_p, cal_p; // Command triggers
    logic [3:0] a_t, a_c, b_t, b_c; // Banks A and B legs
    logic [1:0] c_t, c_c; // Bank C legs
    logic d_t, d_c, se, se_oe_n; // Bank D outputs
    int n_errors = 0; // Mismatches seen
    int n_compared = 0; // Comparisons made
    int n_cycles = 0; // Clock cycles run

    // Clock: half period of 2 ns
    always #2 clk_in = ~clk_in;

    // Device under test
    dcr_device_control i_dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in),
        .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .divider_sync_cmd_out(sync_p), .pll_lock_restart_cmd_out(pll_lock_restart_cmd_p),
        .bias_calibrate_cmd_out(cal_p),
        .bank_d_powerdown_in(pd), .bank_d_single_ended_powerdown_in(sepd),
        .bank_a_clk_in(a_clk), .bank_b_clk_in(b_clk), .bank_c_clk_in(c_clk),
        .bank_d_diff_clk_in(d_clk), .bank_d_single_ended_clk_in(se_clk),
        .bank_a_diff_outputs_true_out(a_t), .bank_a_diff_outputs_comp_out(a_c),
        .bank_b_diff_outputs_true_out(b_t), .bank_b_diff_outputs_comp_out(b_c),
        .bank_c_diff_outputs_true_out(c_t), .bank_c_diff_outputs_comp_out(c_c),
        .bank_d_diff_output_true_out(d_t), .bank_d_diff_output_comp_out(d_c),
        .bank_d_single_ended_out(se), .bank_d_single_ended_oe_n_out(se_oe_n)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    // Compare and report one value
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One write cycle; returns at the falling edge after the take edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk_in);
        wr_en = 1'b0;
    endtask

    // One read cycle; data is settled at the falling edge after the take edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        rd_en = 1'b1;
        addr = a;
        @(negedge clk_in);
        rd_en = 1'b0;
        d = rdata;
    endtask

    // Let the gate settle, then judge every bank output for enables en; the single-ended level only without power-down
    task automatic check_banks(input logic [3:0] en);
        logic d_on;
        d_on = en[0] & ~pd;
        repeat (2) @(negedge clk_in);
        check("bank_a_true", {4'h0, a_t}, en[3] ? {4'h0, a_clk} : 8'h00);
        check("bank_a_comp", {4'h0, a_c}, en[3] ? {4'h0, ~a_clk} : 8'h0f);
        check("bank_b_true", {4'h0, b_t}, en[2] ? {4'h0, b_clk} : 8'h00);
        check("bank_b_comp", {4'h0, b_c}, en[2] ? {4'h0, ~b_clk} : 8'h0f);
        check("bank_c_true", {6'h0, c_t}, en[1] ? {6'h0, c_clk} : 8'h00);
        check("bank_c_comp", {6'h0, c_c}, en[1] ? {6'h0, ~c_clk} : 8'h03);
        check("bank_d_true", {7'h0, d_t}, {7'h0, d_on & d_clk});
        check("bank_d_comp", {7'h0, d_c}, {7'h0, ~(d_on & d_clk)});
        check("se_oe_n", {7'h0, se_oe_n}, {7'h0, pd | sepd});
        if (!(pd | sepd)) begin
            check("se_out", {7'h0, se}, {7'h0, en[0] & se_clk});
        end
    endtask

    // Print the counts and the verdict, then stop
    task automatic give_verdict();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Outputs in reset, then release
    task automatic t_reset();
        repeat (4) @(negedge clk_in);
        check("rst_rdata", rdata, 8'h00);
        check("rst_pulses", {5'h0, sync_p, pll_lock_restart_cmd_p, cal_p}, 8'h00);
        check("rst_a", {a_t, a_c}, 8'h0f);
        check("rst_se_oe_n", {7'h0, se_oe_n}, 8'h01);
        reset_n_in = 1'b1;
    endtask

    // Reset values and read-back of every register and an unmapped one
    task automatic t_defaults();
        logic [7:0] d;
        rd(DCR_ADDR_DIV_SYNC, d);
        check("rd_sync", d, 8'h00);
        rd(DCR_ADDR_PLL_PLL_LOCK_RESTART_CMD, d);
        check("rd_pll_lock_restart_cmd", d, 8'h00);
        rd(DCR_ADDR_BIAS_CAL, d);
        check("rd_cal", d, 8'h00);
        rd(DCR_ADDR_BANK_EN, d);
        check("rd_en_reset", d, 8'h0f);
        rd(8'h41, d);
        check("rd_unmapped", d, 8'h00);
        check_banks(4'hf);
    endtask

    // Each command: zero write does nothing, one write gives one pulse
    task automatic t_commands();
        logic [7:0] cmd_addr [3];
        logic [7:0] d;
        cmd_addr = '{DCR_ADDR_DIV_SYNC, DCR_ADDR_PLL_PLL_LOCK_RESTART_CMD, DCR_ADDR_BIAS_CAL};
        for (int i = 0; i < 3; i++) begin
            wr(cmd_addr[i], 8'h00);
            check("zero_write", {5'h0, sync_p, pll_lock_restart_cmd_p, cal_p}, 8'h00);
            wr(cmd_addr[i], 8'h80);
            check("pulse", {5'h0, sync_p, pll_lock_restart_cmd_p, cal_p}, 8'h04 >> i);
            @(negedge clk_in);
            check("pulse_end", {5'h0, sync_p, pll_lock_restart_cmd_p, cal_p}, 8'h00);
            rd(cmd_addr[i], d);
            check("cmd_read", d, 8'h00);
        end
    endtask

    // Each bank disabled alone, all off, all on again
    task automatic t_enables();
        logic [3:0] en_tab [6];
        logic [7:0] d;
        en_tab = '{4'h7, 4'hb, 4'hd, 4'he, 4'h0, 4'hf};
        for (int i = 0; i < 6; i++) begin
            wr(DCR_ADDR_BANK_EN, {4'h0, en_tab[i]});
            // Flip every bank clock so both levels pass through the gate
            a_clk = ~a_clk;
            b_clk = ~b_clk;
            c_clk = ~c_clk;
            d_clk = ~d_clk;
            se_clk = ~se_clk;
            check_banks(en_tab[i]);
            rd(DCR_ADDR_BANK_EN, d);
            check("rd_en", d, {4'h0, en_tab[i]});
        end
        // Write, then read in the very next cycle: the read sees the new enables
        @(negedge clk_in);
        wr_en = 1'b1;
        addr = DCR_ADDR_BANK_EN;
        wdata = 8'h05;
        @(negedge clk_in);
        wr_en = 1'b0;
        rd_en = 1'b1;
        @(negedge clk_in);
        rd_en = 1'b0;
        check("rd_en_b2b", rdata, 8'h05);
        check_banks(4'h5);
        wr(DCR_ADDR_BANK_EN, 8'h0f);
    endtask

    // Power-down of bank D and of the single-ended output
    task automatic t_powerdown();
        @(negedge clk_in);
        pd = 1'b1;
        check_banks(4'hf);
        pd = 1'b0;
        sepd = 1'b1;
        check_banks(4'hf);
        wr(DCR_ADDR_BANK_EN, 8'h0e);
        check_banks(4'he);
        sepd = 1'b0;
        check_banks(4'he);
    endtask

    // ****************************************************************
    // Main sequence and hang guard
    // ****************************************************************
    initial begin
        t_reset();
        t_defaults();
        t_commands();
        t_enables();
        t_powerdown();
        give_verdict();
    end

    // Cut a hang short well beyond the expected run length
    always @(posedge clk_in) begin
        n_cycles++;
        if (n_cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end
endmodule
